// file: src/acctmr_top.sv
// Accumulating tenth-second timer with Wishbone register access
//
// Overview of operation
// - Start at zero, add one per tick
// - Range 0.1 to 999.9 seconds
// - Time while condition ON, stop at set value
// - Reset bit input clears value, ends timing
// - Advance only in executed scans
// - Interlock off retains present value
// - Jumped section neither times nor clears
// - Power loss clears present value
// - Timed out stays until rewrite or reset
// - Completion flag may lag one scan
// - Set value zero flags on input rise
// - Set value one may flag immediately
// - Interval short by at most one tick
// - Non-BCD word raises error flag
//
// The Wishbone register port and the address map were chosen for this implementation.
module acctmr_top #(
  parameter int unsigned TICK_CYCLES = acctmr_pkg::TBASE_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // Program scan
  input  wire logic        scan_i,
  input  wire logic        exec_cond_i,
  input  wire logic        reset_bit_input_i,
  input  wire logic        interlock_on_i,
  input  wire logic        jumped_i,
  // Timer results
  output logic [15:0]      present_value_o,
  output logic             done_o,
  output logic             error_flag_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] set_value_q;   // Target, BCD
  logic [15:0] pv_q;          // Present value, BCD
  logic [15:0] pv_d;          // Next present value
  logic        done_q;        // Completion flag
  logic        done_d;        // Next completion flag
  logic        err_q;         // Error flag
  logic        err_d;         // Next error flag
  logic        run_q;         // Timed in last scan
  logic        tick;          // Time-base pulse
  logic        tick_pend_q;   // Tick not yet consumed
  logic        ack_q;         // Bus answer
  logic [31:0] rdata_q;       // Read data
  logic [1:0]  irq_stat_q;    // Sticky events
  logic [1:0]  irq_mask_q;    // Event enables
  logic [1:0]  irq_ev;        // Events this cycle
  logic [1:0]  irq_clr;       // Write-one-to-clear bits
  logic        req;           // New bus request
  logic        wr;            // Bus write in its ack cycle
  logic        wr_sv;         // Set value write
  logic        wr_pv;         // Present value write
  logic [15:0] wr_half;       // Low half of write data
  logic [15:0] new_pv;        // Present value after write
  logic        executed;      // Timer executed this scan
  logic        rst_cmd;       // Reset bit taken
  logic        timing;        // Accumulating this scan
  logic        sv_ok;         // Set value is BCD
  logic        pv_ok;         // Present value is BCD

  // BCD units for present and set values
  acctmr_bcd_if pv_bcd ();
  acctmr_bcd_if sv_bcd ();

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  // Present value check and increment
  acctmr_bcd u_pv_bcd (
    .bcd (pv_bcd.unit)
  );

  // Set value check; increment unused
  acctmr_bcd u_sv_bcd (
    .bcd (sv_bcd.unit)
  );

  // Tenth-second time base
  acctmr_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  assign pv_bcd.value = pv_q;
  assign sv_bcd.value = set_value_q;
  assign pv_ok        = pv_bcd.valid;
  assign sv_ok        = sv_bcd.valid;

  // ----------------------------------------------------------------
  // Scan qualification
  // ----------------------------------------------------------------
  // Interlock or jump holds
  assign executed = scan_i & ~jumped_i & interlock_on_i;
  assign rst_cmd  = executed & reset_bit_input_i;
  assign timing   = executed & exec_cond_i & ~reset_bit_input_i & sv_ok;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Request seen in its first cycle only
  assign req   = cyc_i & stb_i & ~ack_q;
  // Write lands at the edge that samples ack, data still held
  assign wr    = cyc_i & stb_i & we_i & ack_q;
  assign wr_sv = wr & (adr_i == acctmr_pkg::OFF_SET_VAL);
  assign wr_pv = wr & (adr_i == acctmr_pkg::OFF_PRES_VAL);

  // Byte lanes of the low half word
  always_comb begin
    wr_half = (adr_i == acctmr_pkg::OFF_SET_VAL) ? set_value_q : pv_q;
    if (sel_i[0]) begin
      wr_half[7:0] = dat_i[7:0];
    end
    if (sel_i[1]) begin
      wr_half[15:8] = dat_i[15:8];
    end
  end
  assign new_pv = wr_half;

  // ----------------------------------------------------------------
  // Tick capture
  // ----------------------------------------------------------------
  // A tick waits for the next scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_pend_q <= 1'b0;
    end else if (tick) begin
      // New tick wins over consumption
      tick_pend_q <= 1'b1;
    end else if (executed) begin
      tick_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timer next state
  // ----------------------------------------------------------------
  always_comb begin
    pv_d   = pv_q;
    done_d = done_q;
    err_d  = err_q;
    if (wr_pv) begin
      pv_d   = new_pv;
      done_d = (new_pv >= set_value_q);
    end else if (rst_cmd) begin
      pv_d   = acctmr_pkg::PV_RST;
      done_d = 1'b0;
    end else if (timing) begin
      if (done_q) begin
        // Timed out, wait for rewrite or reset
        pv_d = pv_q;
      end else if (pv_q >= set_value_q) begin
        pv_d = set_value_q;
      end else if (tick_pend_q) begin
        pv_d = pv_bcd.incr;
      end
      done_d = done_q | (pv_d >= set_value_q);
    end
    if (executed) begin
      err_d = ~sv_ok | ~pv_ok;
    end
  end

  // ----------------------------------------------------------------
  // Timer state
  // ----------------------------------------------------------------
  // Power-up reset clears value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pv_q   <= acctmr_pkg::PV_RST;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      pv_q   <= pv_d;
      done_q <= done_d;
      err_q  <= err_d;
    end
  end

  // Activity of last executed scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (executed) begin
      run_q <= timing & ~done_d;
    end
  end

  // ----------------------------------------------------------------
  // Set value register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_value_q <= acctmr_pkg::SV_RST;
    end else if (wr_sv) begin
      set_value_q <= wr_half;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Completion and error rising edges
  assign irq_ev[acctmr_pkg::IRQ_DONE] = done_d & ~done_q;
  assign irq_ev[acctmr_pkg::IRQ_ERR]  = err_d & ~err_q;
  // Write one clears
  assign irq_clr = (wr & (adr_i == acctmr_pkg::OFF_IRQ_STAT) & sel_i[0])
                   ? dat_i[1:0] : 2'h0;

  // Sticky status, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= acctmr_pkg::IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  // Mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= acctmr_pkg::IRQ_RST;
    end else if (wr & (adr_i == acctmr_pkg::OFF_IRQ_MASK) & sel_i[0]) begin
      irq_mask_q <= dat_i[1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Bus answer and read data
  // ----------------------------------------------------------------
  // Answer one cycle after request, for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req) begin
      unique case (adr_i)
        acctmr_pkg::OFF_SET_VAL:  rdata_q <= {16'h0000, set_value_q};
        acctmr_pkg::OFF_PRES_VAL: rdata_q <= {16'h0000, pv_q};
        acctmr_pkg::OFF_STATUS:   rdata_q <= {29'h0, run_q, err_q, done_q};
        acctmr_pkg::OFF_IRQ_STAT: rdata_q <= {30'h0, irq_stat_q};
        acctmr_pkg::OFF_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
        default:                  rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ack_o           = ack_q;
  assign dat_o           = rdata_q;
  assign present_value_o = pv_q;
  assign done_o          = done_q;
  assign error_flag_o    = err_q;

endmodule // acctmr_top

// file: include/acctmr_pkg.sv
// Constants shared by the accumulating tenth-second timer block
package acctmr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Time base in ns (0.1 s)
  localparam int unsigned TBASE_NS      = 100_000_000;
  // Clock cycles per time-base tick
  localparam int unsigned TBASE_CYC     = TBASE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Value formats
  // ----------------------------------------------------------------
  // Four BCD digits
  localparam int unsigned BCD_W       = 16;
  localparam int unsigned BCD_DIGITS  = 4;
  // Largest count, 999.9 s
  localparam logic [15:0] BCD_MAX     = 16'h9999;
  // Reset values of set value and present value
  localparam logic [15:0] SV_RST      = 16'h0000;
  localparam logic [15:0] PV_RST      = 16'h0000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam logic [7:0]  OFF_SET_VAL  = 8'h00;
  localparam logic [7:0]  OFF_PRES_VAL = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h10;

  // Status register bits
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_ERR  = 1;
  localparam int unsigned ST_RUN  = 2;
  // Interrupt status and mask bits
  localparam int unsigned IRQ_W    = 2;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_ERR  = 1;
  localparam logic [1:0]  IRQ_RST  = 2'h0;

endpackage

// file: include/acctmr_bcd_if.sv
// Carrier between the timer core and one BCD digit unit
interface acctmr_bcd_if;
  logic [15:0] value; // Four-digit BCD operand
  logic        valid; // Every digit is 0 to 9
  logic [15:0] incr;  // Operand plus one, saturating

  // Digit unit side
  modport unit (input value, output valid, output incr);
  // Timer core side
  modport user (output value, input valid, input incr);
endinterface

// file: src/acctmr_bcd.sv
// Four-digit BCD validity check and saturating increment
module acctmr_bcd (
  // Operand and results
  acctmr_bcd_if.unit bcd
);

  logic [3:0] digit;  // Current digit
  logic       carry;  // Ripple carry into digit
  logic       ok;     // Running validity
  logic [15:0] sum;   // Incremented value

  // ----------------------------------------------------------------
  // Digit ripple
  // ----------------------------------------------------------------
  always_comb begin
    carry = 1'b1;
    ok    = 1'b1;
    sum   = bcd.value;
    digit = 4'h0;
    for (int i = 0; i < acctmr_pkg::BCD_DIGITS; i++) begin
      digit = bcd.value[4*i +: 4];
      // Digit above nine marks the word illegal
      if (digit > 4'h9) begin
        ok = 1'b0;
      end
      if (carry) begin
        // Nine rolls to zero and carries on
        if (digit == 4'h9) begin
          sum[4*i +: 4] = 4'h0;
        end else begin
          sum[4*i +: 4] = digit + 4'h1;
          carry         = 1'b0;
        end
      end
    end
  end

  // Saturate at all nines
  assign bcd.valid = ok;
  assign bcd.incr  = (bcd.value == acctmr_pkg::BCD_MAX) ? bcd.value : sum;

endmodule // acctmr_bcd

// file: src/acctmr_tick.sv
// Time-base tick generator, one pulse per period
module acctmr_tick #(
  parameter int unsigned CYCLES = 10
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // One-cycle tick
  output logic      tick_o
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q; // Cycle count within period

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      tick_o <= 1'b0;
    end
  end

endmodule // acctmr_tick

// file: tb/acctmr_scan_model.sv
// Program scan model that executes the timer at a chosen spacing
module acctmr_scan_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Scan spacing in cycles, zero stops the scan
  input  wire logic [3:0] gap_i,
  // One-cycle execute pulse
  output logic            scan_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cnt_q;  // Cycles since last scan

  always_ff @(posedge clk_i) begin
    if (rst_i || gap_i == 4'h0) begin
      cnt_q  <= 4'h0;
      scan_o <= 1'b0;
    end else begin
      scan_o <= (cnt_q == 4'h0);
      cnt_q  <= (cnt_q + 4'h1 >= gap_i) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule // acctmr_scan_model

// file: tb/acctmr_chk.sv
// Port-level assertions for the accumulating timer
module acctmr_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus and scan inputs
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        scan_i,
  input wire logic        exec_cond_i,
  input wire logic        reset_bit_input_i,
  input wire logic        interlock_on_i,
  input wire logic        jumped_i,
  // Timer results
  input wire logic [15:0] present_value_o,
  input wire logic        done_o,
  input wire logic        error_flag_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic exe;  // Executed scan
  logic wr;   // Bus write in flight
  assign exe = scan_i & interlock_on_i & ~jumped_i;
  assign wr  = cyc_i & stb_i & we_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus request and its single answer
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ack_o ##1 !ack_o;
  endsequence

  AST_ACK_ONCE: assert property (s_req |=> s_answer)
    else $error("ack not a single pulse after request");
  AST_RST_CLEAR: assert property (
    $fell(rst_i) |-> present_value_o == 16'h0000 && !done_o)
    else $error("outputs not clear after reset");
  AST_NO_SCAN: assert property (!scan_i && !wr |=> $stable(present_value_o))
    else $error("value moved without a scan");
  AST_INTERLOCK: assert property (
    scan_i && !interlock_on_i && !wr |=> $stable(present_value_o))
    else $error("value moved while interlocked");
  AST_JUMPED: assert property (
    scan_i && jumped_i && !wr |=> $stable(present_value_o))
    else $error("value moved while jumped");
  AST_COND_OFF: assert property (
    exe && !exec_cond_i && !reset_bit_input_i && !wr |=> $stable(present_value_o))
    else $error("value moved with condition off");
  AST_RESET_BIT: assert property (
    exe && reset_bit_input_i && !wr |=> present_value_o == 16'h0000 && !done_o)
    else $error("reset bit did not clear");
  AST_DONE_HOLD: assert property (
    done_o && !(exe && reset_bit_input_i) && !wr |=> done_o)
    else $error("completion dropped without reset or rewrite");
  AST_ERR_SCAN: assert property (!exe && !wr |=> $stable(error_flag_o))
    else $error("error flag moved outside a scan");
endmodule // acctmr_chk

bind acctmr_top acctmr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .scan_i(scan_i), .exec_cond_i(exec_cond_i),
  .reset_bit_input_i(reset_bit_input_i), .interlock_on_i(interlock_on_i),
  .jumped_i(jumped_i), .present_value_o(present_value_o), .done_o(done_o),
  .error_flag_o(error_flag_o));

// file: tb/accumulating_tenth_second_timer_bench.sv
// Self-checking bench for the accumulating timer
module accumulating_tenth_second_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i, rst_i, we, cyc, stb, ack, scan, cond, rbit, ilk, jmp, done, err, irq;
  logic [7:0]  adr;        // Bus address
  logic [31:0] wdat, rdat; // Bus data
  logic [15:0] pv, hold;   // Present value and saved copy
  logic [3:0]  gap;        // Scan spacing
  logic [31:0] q;          // Read result
  int bad_count, samples_checked, n;

  acctmr_top #(.TICK_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .scan_i(scan), .exec_cond_i(cond), .reset_bit_input_i(rbit), .interlock_on_i(ilk),
    .jumped_i(jmp), .present_value_o(pv), .done_o(done), .error_flag_o(err), .irq_o(irq));
  acctmr_scan_model u_scan (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .scan_o(scan));

  // Clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic Wishbone cycle
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    adr <= a; we <= w; wdat <= d; cyc <= 1'b1; stb <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (k >= 50) chk("ack", 1, 0);
    // Let the write land before anyone looks
    @(posedge clk_i);
  endtask

  // Wait until done reaches v, counting cycles
  task automatic wait_done(input logic v, input int lim);
    n = 0;
    while (done !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1; adr = 8'h00; wdat = 32'h0; we = 1'b0; cyc = 1'b0; stb = 1'b0;
    cond = 1'b0; rbit = 1'b0; ilk = 1'b1; jmp = 1'b0; gap = 4'h4;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(8'(i * 4), 1'b0, 32'h0);
      chk("reset reg", 32'h0, q);
    end
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h0003);
    wb(acctmr_pkg::OFF_IRQ_MASK, 1'b1, 32'h0003);
    cond <= 1'b1;
    wait_done(1'b1, 400);
    chk("interval", 1, n >= 40 && n <= 66);
    chk("pv at done", 16'h0003, pv);
    chk("irq done", 1, irq);
    repeat (60) @(posedge clk_i);
    chk("pv held", 16'h0003, pv);
    chk("done held", 1, done);
    wb(acctmr_pkg::OFF_IRQ_STAT, 1'b1, 32'h0001);
    chk("irq cleared", 0, irq);
    wb(acctmr_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000);
    // Raising the target alone must not restart a timed-out timer
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h0005);
    repeat (60) @(posedge clk_i);
    chk("stopped pv", 16'h0003, pv);
    chk("stopped done", 1, done);
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h0003);
    wb(acctmr_pkg::OFF_PRES_VAL, 1'b1, 32'h0001);
    chk("done after rewrite", 0, done);
    wait_done(1'b1, 400);
    chk("restart pv", 16'h0003, pv);
    chk("irq masked", 0, irq);
    wb(acctmr_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("irq stat", 1, q[0]);
    rbit <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("reset bit pv", 16'h0000, pv);
    chk("reset bit done", 0, done);
    rbit <= 1'b0;
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h9999);
    n = 0;
    while (pv === 16'h0000 && n < 900) begin
      @(posedge clk_i);
      n++;
    end
    chk("first count", 16'h0001, pv);
    wb(acctmr_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk("status running", 32'h0000_0004, q);
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: ilk <= 1'b0;
        1: jmp <= 1'b1;
        2: cond <= 1'b0;
        default: gap <= 4'h0;
      endcase
      // A scan pulse already launched may still land
      repeat (2) @(posedge clk_i);
      hold = pv;
      repeat (100) @(posedge clk_i);
      chk("held pv", hold, pv);
      ilk <= 1'b1;
      jmp <= 1'b0;
      cond <= 1'b1;
      gap <= 4'h4;
      @(posedge clk_i);
    end
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h00A0);
    repeat (8) @(posedge clk_i);
    chk("error flag", 1, err);
    wb(acctmr_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("irq error stat", 1, q[1]);
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h0010);
    wb(acctmr_pkg::OFF_PRES_VAL, 1'b1, 32'h0009);
    repeat (8) @(posedge clk_i);
    chk("error gone", 0, err);
    wait_done(1'b1, 400);
    chk("bcd carry", 16'h0010, pv);
    cond <= 1'b0;
    rbit <= 1'b1;
    gap <= 4'h1;
    repeat (8) @(posedge clk_i);
    rbit <= 1'b0;
    wb(acctmr_pkg::OFF_SET_VAL, 1'b1, 32'h0000);
    repeat (8) @(posedge clk_i);
    chk("sv zero idle", 0, done);
    cond <= 1'b1;
    wait_done(1'b1, 20);
    chk("sv zero rise", 1, n <= 4);
    chk("sv zero pv", 16'h0000, pv);
    conclude();
  end
endmodule // accumulating_tenth_second_timer_bench
